// ### ucm_pkg.sv
// Summary of operation
// (RQ1) Mode one bit 7 enables automatic receive RTS
// (RQ2) Mode one bit 6 picks available/full interrupt source
// (RQ3) Mode one bit 5: character or block errors
// (RQ4) Character mode drops errors on read; command clears
// (RQ5) Parity field: with, forced, none, multidrop
// (RQ6) Mode one bit 2: parity sense or address flag
// (RQ7) Multidrop uses parity slot for address flag
// (RQ8) Mode two bits 7:6 select channel loop mode
// (RQ9) External 1X transmit clock: bit 3 two stops
// (RQ10) Clock code maps to rate, set by aux bit 7
// (RQ11) Receiver clock is 16X except code 1111
// (RQ12) Mode pointer starts at one, moves to two
`default_nettype none
package ucm_pkg;
  // Word-aligned byte offsets of the register window
  localparam logic [4:0] OFS_MODE     = 5'h00;
  localparam logic [4:0] OFS_CLK_SEL  = 5'h04;
  localparam logic [4:0] OFS_COMMAND  = 5'h08;
  localparam logic [4:0] OFS_AUX_CTRL = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
  localparam logic [4:0] OFS_STATUS   = 5'h18;
  // Mode one fields
  localparam int M1_RTS_BIT   = 7;
  localparam int M1_IRQ_BIT   = 6;
  localparam int M1_ERR_BIT   = 5;
  localparam int M1_PAR_HI    = 4;
  localparam int M1_PAR_LO    = 3;
  localparam int M1_TYPE_BIT  = 2;
  // Mode two fields
  localparam int M2_CHM_HI    = 7;
  localparam int M2_CHM_LO    = 6;
  localparam int M2_STOP_BIT  = 3;
  // Aux control rate set select
  localparam int AUX_SET_BIT  = 7;
  // Command codes, low nibble of the command write
  localparam logic [3:0] CMD_RST_PTR = 4'h1;
  localparam logic [3:0] CMD_RST_ERR = 4'h4;
  // Clock codes for the external 1X and 16X pin clocks and the timer
  localparam logic [3:0] CODE_PIN_1X  = 4'hF;
  localparam logic [3:0] CODE_PIN_16X = 4'hE;
  localparam logic [3:0] CODE_TIMER   = 4'hD;
  // Reset values
  localparam logic [7:0] MODE_RST     = 8'h00;
  localparam logic [7:0] CSEL_RST     = 8'h00;
  localparam logic [7:0] AUX_RST      = 8'h00;
  localparam logic [2:0] IRQ_RST      = 3'h0;
  // Interrupt status bit positions
  localparam int IRQ_RX_BIT   = 0;
  localparam int IRQ_ERR_BIT  = 1;
  localparam int IRQ_ADDR_BIT = 2;

  typedef enum logic [1:0] {
    PAR_WITH  = 2'b00,
    PAR_FORCE = 2'b01,
    PAR_NONE  = 2'b10,
    PAR_MDROP = 2'b11
  } ucm_par_mode_t;

  typedef enum logic [1:0] {
    CHM_NORMAL = 2'b00,
    CHM_ECHO   = 2'b01,
    CHM_LLOOP  = 2'b10,
    CHM_RLOOP  = 2'b11
  } ucm_chan_mode_t;

  typedef enum logic [1:0] {
    SRC_FIXED  = 2'b00,
    SRC_TIMER  = 2'b01,
    SRC_PIN16  = 2'b10,
    SRC_PIN1   = 2'b11
  } ucm_clk_src_t;

  typedef struct packed {
    logic           rts_auto;
    logic           irq_on_full;
    logic           err_block;
    ucm_par_mode_t  par_mode;
    logic           par_type;
    ucm_chan_mode_t chan_mode;
    logic           two_stop;
    logic [3:0]     stop_code;
    ucm_clk_src_t   rx_src;
    ucm_clk_src_t   tx_src;
    logic           rx_is_16x;
    logic           tx_is_16x;
    logic [19:0]    rx_baud_x10;
    logic [19:0]    tx_baud_x10;
  } ucm_cfg_t;
endpackage : ucm_pkg
`default_nettype wire

// ### ucm_top.sv
`timescale 1ns/1ps
`default_nettype none
module ucm_top (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [4:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  input  wire logic              RX_CHAR_AVAILABLE,
  input  wire logic              RX_QUEUE_FULL_FLAG,
  input  wire logic              RX_PUSH,
  input  wire logic [2:0]        RX_PUSH_ERR,
  input  wire logic              RX_PUSH_PAR_BIT,
  input  wire logic              RX_POP,
  input  wire logic [2:0]        RX_HEAD_ERR,
  input  wire logic              TX_DATA_XOR,
  input  wire logic              RTS_GP_LEVEL,
  output ucm_pkg::ucm_cfg_t      CFG,
  output logic                   RX_IRQ_REQ,
  output logic                   RTS_OUT,
  output logic [2:0]             ERR_STATUS,
  output logic                   TX_PAR_EN,
  output logic                   TX_PAR_BIT,
  output logic                   RX_ADDR_FLAG,
  output logic                   RX_CHECK_PARITY,
  output logic                   IRQ
);
  import ucm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Baud rate table, rate times ten, zero where no fixed rate applies
  function automatic logic [19:0] rate_x10(input logic set2, input logic [3:0] code);
    logic [19:0] r;
    r = 20'h00000;
    case (code)
      4'h0: r = set2 ? 20'd750 : 20'd500;
      4'h1: r = 20'd1100;
      4'h2: r = 20'd1345;
      4'h3: r = set2 ? 20'd1500 : 20'd2000;
      4'h4: r = 20'd3000;
      4'h5: r = 20'd6000;
      4'h6: r = 20'd12000;
      4'h7: r = set2 ? 20'd20000 : 20'd10500;
      4'h8: r = 20'd24000;
      4'h9: r = 20'd48000;
      4'hA: r = set2 ? 20'd18000 : 20'd72000;
      4'hB: r = 20'd96000;
      4'hC: r = set2 ? 20'd192000 : 20'd384000;
      default: r = 20'h00000;
    endcase
    return r;
  endfunction : rate_x10

  function automatic ucm_clk_src_t src_of(input logic [3:0] code);
    ucm_clk_src_t s;
    case (code)
      CODE_TIMER:   s = SRC_TIMER;
      CODE_PIN_16X: s = SRC_PIN16;
      CODE_PIN_1X:  s = SRC_PIN1;
      default:      s = SRC_FIXED;
    endcase
    return s;
  endfunction : src_of

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        req;
  logic        wr_take;
  logic        rd_take;

  assign req     = WB_CYC_I & WB_STB_I;
  // Write and read side effects happen on the edge where ack is seen
  assign wr_take = req & WB_WE_I & ack_q & WB_SEL_I[0];
  assign rd_take = req & ~WB_WE_I & ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] mode1_q, mode1_d;
  logic [7:0] mode2_q, mode2_d;
  logic [7:0] csel_q, csel_d;
  logic [7:0] aux_q, aux_d;
  logic       ptr2_q, ptr2_d;
  logic [2:0] ist_q, ist_d;
  logic [2:0] imask_q, imask_d;
  logic [2:0] err_q, err_d;
  logic       rxsrc_q, rxsrc_d;
  logic       errany_q, errany_d;
  logic       addr_q, addr_d;
  logic [2:0] ev;
  logic       rx_src_now;
  logic       cmd_rst_ptr;
  logic       cmd_rst_err;

  assign cmd_rst_ptr = wr_take & (WB_ADR_I == OFS_COMMAND) & (WB_DAT_I[3:0] == CMD_RST_PTR);
  assign cmd_rst_err = wr_take & (WB_ADR_I == OFS_COMMAND) & (WB_DAT_I[3:0] == CMD_RST_ERR);
  // Source of the receiver interrupt request
  assign rx_src_now  = mode1_q[M1_IRQ_BIT] ? RX_QUEUE_FULL_FLAG : RX_CHAR_AVAILABLE; // see (RQ2)

  always_comb begin
    mode1_d  = mode1_q;
    mode2_d  = mode2_q;
    csel_d   = csel_q;
    aux_d    = aux_q;
    ptr2_d   = ptr2_q;
    imask_d  = imask_q;
    err_d    = err_q;
    addr_d   = addr_q;
    ack_d    = req & ~ack_q;
    rdat_d   = 32'h00000000;
    // Mode window goes through the pointer; any read, or a write with WB_SEL_I[0] set, moves it on
    if ((wr_take | rd_take) && WB_ADR_I == OFS_MODE) begin
      ptr2_d = 1'b1; // see (RQ12)
    end
    if (wr_take) begin
      case (WB_ADR_I)
        OFS_MODE: begin
          if (ptr2_q) begin
            mode2_d = WB_DAT_I[7:0];
          end else begin
            mode1_d = WB_DAT_I[7:0]; // see (RQ12)
          end
        end
        OFS_CLK_SEL:  csel_d  = WB_DAT_I[7:0];
        OFS_AUX_CTRL: aux_d   = WB_DAT_I[7:0];
        OFS_IRQ_MASK: imask_d = WB_DAT_I[2:0];
        default: ;
      endcase
    end
    if (cmd_rst_ptr) begin
      ptr2_d = 1'b0; // see (RQ12)
    end
    // Read data is built while ack rises so it stands with ack
    if (req && !WB_WE_I && !ack_q) begin
      case (WB_ADR_I)
        OFS_MODE:     rdat_d = {24'h000000, ptr2_q ? mode2_q : mode1_q};
        OFS_AUX_CTRL: rdat_d = {24'h000000, aux_q};
        OFS_IRQ_STAT: rdat_d = {29'h00000000, ist_q};
        OFS_IRQ_MASK: rdat_d = {29'h00000000, imask_q};
        OFS_STATUS:   rdat_d = {24'h000000, ptr2_q, RX_ADDR_FLAG, 3'h0, err_q};
        default:      rdat_d = 32'h00000000;
      endcase
    end
    // Error status: character mode follows the FIFO head, block mode gathers
    if (mode1_q[M1_ERR_BIT]) begin // see (RQ3)
      if (cmd_rst_err) begin
        err_d = 3'h0; // see (RQ4)
      end
      if (RX_PUSH) begin
        err_d = err_d | RX_PUSH_ERR;
      end
    end else begin
      err_d = RX_CHAR_AVAILABLE ? RX_HEAD_ERR : 3'h0;
      if (RX_POP || cmd_rst_err) begin
        err_d = 3'h0; // see (RQ4)
      end
    end
    // Received parity slot carries the address flag in multidrop
    if (RX_PUSH && mode1_q[M1_PAR_HI:M1_PAR_LO] == PAR_MDROP) begin
      addr_d = RX_PUSH_PAR_BIT; // see (RQ7)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events; set wins over the read clear
  assign ev[IRQ_RX_BIT]   = rx_src_now & ~rxsrc_q;
  assign ev[IRQ_ERR_BIT]  = (|err_q) & ~errany_q;
  assign ev[IRQ_ADDR_BIT] = RX_PUSH & RX_PUSH_PAR_BIT & (mode1_q[M1_PAR_HI:M1_PAR_LO] == PAR_MDROP);

  always_comb begin
    ist_d    = ist_q;
    rxsrc_d  = rx_src_now;
    errany_d = |err_q;
    if (rd_take && WB_ADR_I == OFS_IRQ_STAT) begin
      ist_d = IRQ_RST;
    end
    ist_d = ist_d | ev;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ack_q    <= 1'b0;
      rdat_q   <= 32'h00000000;
      mode1_q  <= MODE_RST;
      mode2_q  <= MODE_RST;
      csel_q   <= CSEL_RST;
      aux_q    <= AUX_RST;
      ptr2_q   <= 1'b0;
      ist_q    <= IRQ_RST;
      imask_q  <= IRQ_RST;
      err_q    <= 3'h0;
      rxsrc_q  <= 1'b0;
      errany_q <= 1'b0;
      addr_q   <= 1'b0;
    end else begin
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
      mode1_q  <= mode1_d;
      mode2_q  <= mode2_d;
      csel_q   <= csel_d;
      aux_q    <= aux_d;
      ptr2_q   <= ptr2_d;
      ist_q    <= ist_d;
      imask_q  <= imask_d;
      err_q    <= err_d;
      rxsrc_q  <= rxsrc_d;
      errany_q <= errany_d;
      addr_q   <= addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  ucm_par_mode_t pmode;
  logic          txpar;

  assign pmode = ucm_par_mode_t'(mode1_q[M1_PAR_HI:M1_PAR_LO]); // see (RQ5)

  always_comb begin
    CFG             = '0;
    CFG.rts_auto    = mode1_q[M1_RTS_BIT]; // see (RQ1)
    CFG.irq_on_full = mode1_q[M1_IRQ_BIT]; // see (RQ2)
    CFG.err_block   = mode1_q[M1_ERR_BIT]; // see (RQ3)
    CFG.par_mode    = pmode;
    CFG.par_type    = mode1_q[M1_TYPE_BIT]; // see (RQ6)
    CFG.chan_mode   = ucm_chan_mode_t'(mode2_q[M2_CHM_HI:M2_CHM_LO]); // see (RQ8)
    CFG.stop_code   = mode2_q[3:0];
    // Only an external 1X transmit clock uses the whole-bit stop choice
    CFG.two_stop    = (csel_q[3:0] == CODE_PIN_1X) & mode2_q[M2_STOP_BIT]; // see (RQ9)
    CFG.rx_src      = src_of(csel_q[7:4]);
    CFG.tx_src      = src_of(csel_q[3:0]);
    CFG.rx_is_16x   = (csel_q[7:4] != CODE_PIN_1X); // see (RQ11)
    CFG.tx_is_16x   = (csel_q[3:0] != CODE_PIN_1X);
    CFG.rx_baud_x10 = rate_x10(aux_q[AUX_SET_BIT], csel_q[7:4]); // see (RQ10)
    CFG.tx_baud_x10 = rate_x10(aux_q[AUX_SET_BIT], csel_q[3:0]); // see (RQ10)
  end

  // Transmit parity slot value for each parity mode
  always_comb begin
    case (pmode)
      PAR_WITH:  txpar = TX_DATA_XOR ^ mode1_q[M1_TYPE_BIT]; // see (RQ6)
      PAR_FORCE: txpar = mode1_q[M1_TYPE_BIT];                // see (RQ6)
      PAR_MDROP: txpar = mode1_q[M1_TYPE_BIT];                // see (RQ7)
      default:   txpar = 1'b0;
    endcase
  end

  assign TX_PAR_BIT      = txpar;
  assign TX_PAR_EN       = (pmode != PAR_NONE);
  assign RX_CHECK_PARITY = (pmode == PAR_WITH) | (pmode == PAR_FORCE);
  assign RX_ADDR_FLAG    = addr_q;
  assign RX_IRQ_REQ      = rx_src_now;
  // Automatic RTS drops while the receive queue is full
  assign RTS_OUT         = mode1_q[M1_RTS_BIT] ? ~RX_QUEUE_FULL_FLAG : RTS_GP_LEVEL; // see (RQ1)
  assign ERR_STATUS      = err_q;
  assign IRQ             = |(ist_q & imask_q);
  assign WB_ACK_O        = ack_q;
  assign WB_DAT_O        = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ptr_moves_on: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ12)
    (req && ack_q && WB_ADR_I == OFS_MODE && !cmd_rst_ptr) |=> ptr2_q)
    else $error("mode pointer did not advance");
  a_ptr_reset_cmd: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ12)
    cmd_rst_ptr |=> !ptr2_q)
    else $error("mode pointer not reset by command");
  a_first_mode_wr: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ12)
    (wr_take && WB_ADR_I == OFS_MODE && !ptr2_q) |=> mode1_q == $past(WB_DAT_I[7:0]))
    else $error("first mode write lost");
  a_rts_auto_full: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ1)
    (CFG.rts_auto && RX_QUEUE_FULL_FLAG) |-> !RTS_OUT)
    else $error("auto RTS asserted while full");
  a_irq_src_sel: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ2)
    RX_IRQ_REQ == (CFG.irq_on_full ? RX_QUEUE_FULL_FLAG : RX_CHAR_AVAILABLE))
    else $error("wrong receive interrupt source");
  a_err_char_pop: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ4)
    (!CFG.err_block && RX_POP && !$changed(mode1_q)) |=> ERR_STATUS == 3'h0)
    else $error("error bits kept after read");
  a_err_block_hold: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ3)
    (CFG.err_block && $past(CFG.err_block) && !$past(cmd_rst_err)) |->
      ((ERR_STATUS & $past(ERR_STATUS)) == $past(ERR_STATUS)))
    else $error("block errors not accumulated");
  a_mdrop_txbit: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ7)
    (CFG.par_mode == PAR_MDROP) |-> (TX_PAR_EN && TX_PAR_BIT == CFG.par_type))
    else $error("address flag not in parity slot");
  a_two_stop_1x: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ9)
    CFG.two_stop |-> (CFG.tx_src == SRC_PIN1 && !CFG.tx_is_16x))
    else $error("two stops without 1X clock");
  a_rate_0111: assert property (@(posedge CLK) disable iff (SYS_RST) // see (RQ10)
    (csel_q[7:4] == 4'h7) |-> CFG.rx_baud_x10 == (aux_q[7] ? 20'd20000 : 20'd10500))
    else $error("rate set decode wrong");
  a_ack_one_cycle: assert property (@(posedge CLK) disable iff (SYS_RST)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held past one cycle");
  a_ack_after_req: assert property (@(posedge CLK) disable iff (SYS_RST)
    (req && !ack_q) |=> WB_ACK_O)
    else $error("ack not given one cycle after request");
endmodule : ucm_top
`default_nettype wire

// ### ucm_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// Receive side of the channel datapath: a four-deep character queue
module ucm_line_model (
  input  wire logic       CLK,
  output logic            RX_CHAR_AVAILABLE,
  output logic            RX_QUEUE_FULL_FLAG,
  output logic            RX_PUSH,
  output logic [2:0]      RX_PUSH_ERR,
  output logic            RX_PUSH_PAR_BIT,
  output logic            RX_POP,
  output logic [2:0]      RX_HEAD_ERR
);
  logic [2:0] cnt = 3'h0;
  logic [2:0] fifo [4] = '{3'h0, 3'h0, 3'h0, 3'h0};
  initial begin
    RX_PUSH = 1'b0;
    RX_POP = 1'b0;
    RX_PUSH_ERR = 3'h5;
    RX_PUSH_PAR_BIT = 1'b0;
  end
  assign RX_CHAR_AVAILABLE  = (cnt != 3'h0);
  assign RX_QUEUE_FULL_FLAG = (cnt == 3'h4);
  // With the queue empty the head lines carry no character
  assign RX_HEAD_ERR = RX_CHAR_AVAILABLE ? fifo[0] : ~fifo[0];
  task automatic push(input logic [2:0] e, input logic p);
    @(posedge CLK);
    RX_PUSH         <= 1'b1;
    RX_PUSH_ERR     <= e;
    RX_PUSH_PAR_BIT <= p;
    fifo[cnt[1:0]]  <= e;
    cnt             <= cnt + 3'h1;
    @(posedge CLK);
    RX_PUSH         <= 1'b0;
    // Lines between characters carry no meaning
    RX_PUSH_ERR     <= ~e;
    RX_PUSH_PAR_BIT <= ~p;
  endtask : push
  task automatic pop();
    @(posedge CLK);
    RX_POP  <= 1'b1;
    fifo[0] <= fifo[1];
    fifo[1] <= fifo[2];
    fifo[2] <= fifo[3];
    cnt     <= cnt - 3'h1;
    @(posedge CLK);
    RX_POP  <= 1'b0;
  endtask : pop
endmodule : ucm_line_model
`default_nettype wire

// ### tb_ucm_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module tb_ucm_top;
  import ucm_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] dati = 32'h0;
  logic [31:0] dato;
  logic        ack;
  logic        txx = 1'b0;
  logic        gp = 1'b0;
  logic        avail, full, push, ppar, pop, irq, rxirq, rts, pen, pbit, aflag, chkp;
  logic [2:0]  perr, herr, err;
  ucm_cfg_t    cfg;
  int          mismatches = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'h8BE1B899;
  logic [31:0] exp_q [$];
  logic [31:0] exp_v;
  logic [7:0]  m1, m2;
  ucm_par_mode_t  pm [4] = '{PAR_WITH, PAR_FORCE, PAR_NONE, PAR_MDROP};
  ucm_chan_mode_t cm [4] = '{CHM_NORMAL, CHM_ECHO, CHM_LLOOP, CHM_RLOOP};
  int baud [2][13] = '{'{500, 1100, 1345, 2000, 3000, 6000, 12000, 10500, 24000, 48000,
                         72000, 96000, 384000},
                       '{750, 1100, 1345, 1500, 3000, 6000, 12000, 20000, 24000, 48000,
                         18000, 96000, 192000}};
  always #10 clk = ~clk;
  ucm_top u_dut (.CLK(clk), .SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dati), .WB_DAT_O(dato),
    .WB_ACK_O(ack), .RX_CHAR_AVAILABLE(avail), .RX_QUEUE_FULL_FLAG(full),
    .RX_PUSH(push), .RX_PUSH_ERR(perr), .RX_PUSH_PAR_BIT(ppar), .RX_POP(pop),
    .RX_HEAD_ERR(herr), .TX_DATA_XOR(txx), .RTS_GP_LEVEL(gp), .CFG(cfg),
    .RX_IRQ_REQ(rxirq), .RTS_OUT(rts), .ERR_STATUS(err), .TX_PAR_EN(pen),
    .TX_PAR_BIT(pbit), .RX_ADDR_FLAG(aflag), .RX_CHECK_PARITY(chkp), .IRQ(irq));
  ucm_line_model u_line (.CLK(clk), .RX_CHAR_AVAILABLE(avail), .RX_QUEUE_FULL_FLAG(full),
    .RX_PUSH(push), .RX_PUSH_ERR(perr), .RX_PUSH_PAR_BIT(ppar), .RX_POP(pop),
    .RX_HEAD_ERR(herr));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    dati <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) mismatches++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wb_rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask : wb_rd
  task automatic conclude();
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // Read answers are compared in the cycle they stand
  always @(posedge clk) begin
    if (ack === 1'b1 && !we && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK(dato, exp_v)
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    wb_rd(OFS_STATUS, 8'h00);
    wb_rd(OFS_MODE, MODE_RST);
    wb_rd(OFS_STATUS, 8'h80);
    wb_rd(OFS_CLK_SEL, 8'h00);
    wb(1'b1, 5'h1C, 8'hFF);
    wb_rd(5'h1C, 8'h00);
    for (int i = 0; i < 4; i++) begin
      m1 = (8'(rnd()) & 8'hE7) | 8'(i << 3);
      m2 = (8'(rnd()) & 8'h3F) | 8'(i << 6);
      wb(1'b1, OFS_COMMAND, {4'h0, CMD_RST_PTR});
      wb(1'b1, OFS_MODE, m1);
      wb(1'b1, OFS_MODE, m2);
      wb_rd(OFS_MODE, m2);
      txx <= seed[9];
      gp  <= seed[11];
      if (i == 3) u_line.push(3'h0, seed[4]);
      @(negedge clk);
      `CHK(cfg.rts_auto, m1[7])
      `CHK(cfg.irq_on_full, m1[6])
      `CHK(cfg.err_block, m1[5])
      `CHK(cfg.par_mode, pm[i])
      `CHK(cfg.par_type, m1[2])
      `CHK(cfg.chan_mode, cm[i])
      `CHK(cfg.stop_code, m2[3:0])
      `CHK(rts, m1[7] ? ~full : gp)
      `CHK(rxirq, m1[6] ? full : avail)
      `CHK(pen, (i != 2))
      `CHK(chkp, (i < 2))
      if (i != 2) `CHK(pbit, (i == 0) ? (txx ^ m1[2]) : m1[2])
      if (i == 3) `CHK(aflag, seed[4])
      if (i == 3) u_line.pop();
      // Sticky events of the multidrop character: source rise and address flag
      if (i == 3) wb_rd(OFS_IRQ_STAT, {5'h00, seed[4], 1'b0, ~m1[6]});
    end
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, OFS_AUX_CTRL, 8'(s << 7));
      wb(1'b1, OFS_MODE, 8'(s << 3));
      for (int c = 0; c < 16; c++) begin
        wb(1'b1, OFS_CLK_SEL, {c[3:0], c[3:0]});
        @(negedge clk);
        `CHK(cfg.rx_baud_x10, (c < 13) ? 20'(baud[s][c]) : 20'h0)
        `CHK(cfg.tx_baud_x10, (c < 13) ? 20'(baud[s][c]) : 20'h0)
        `CHK(cfg.rx_is_16x, (c != 15))
        `CHK(cfg.two_stop, (c == 15 && s == 1))
        `CHK(cfg.tx_is_16x, (c != 15))
        `CHK(cfg.rx_src, (c < 13) ? SRC_FIXED : ucm_clk_src_t'(c - 12))
        `CHK(cfg.tx_src, (c < 13) ? SRC_FIXED : ucm_clk_src_t'(c - 12))
      end
    end
    wb(1'b1, OFS_COMMAND, {4'h0, CMD_RST_PTR});
    wb(1'b1, OFS_MODE, 8'hF0);
    wb(1'b1, OFS_IRQ_MASK, 8'h02);
    wb_rd(OFS_IRQ_STAT, 8'h00);
    u_line.push(3'h2, 1'b0);
    u_line.push(3'h1, 1'b0);
    u_line.push(3'h0, 1'b0);
    u_line.push(3'h0, 1'b0);
    repeat (2) @(negedge clk);
    `CHK(err, 3'h3)
    `CHK(rts, 1'b0)
    `CHK(rxirq, 1'b1)
    `CHK(irq, 1'b1)
    wb_rd(OFS_IRQ_STAT, 8'h03);
    wb(1'b1, OFS_COMMAND, {4'h0, CMD_RST_ERR});
    @(negedge clk);
    `CHK(irq, 1'b0)
    `CHK(err, 3'h0)
    repeat (4) u_line.pop();
    // Pointer sits at mode two after the block-mode setup; bring it back
    wb(1'b1, OFS_COMMAND, {4'h0, CMD_RST_PTR});
    wb(1'b1, OFS_MODE, 8'h10);
    wb(1'b1, OFS_IRQ_MASK, 8'h00);
    u_line.push(3'h4, 1'b0);
    repeat (2) @(negedge clk);
    `CHK(err, 3'h4)
    `CHK(irq, 1'b0)
    wb(1'b1, OFS_IRQ_MASK, 8'h02);
    u_line.pop();
    repeat (2) @(negedge clk);
    `CHK(err, 3'h0)
    `CHK(irq, 1'b1)
    conclude();
  end
endmodule : tb_ucm_top
`default_nettype wire
